// ==== hw/cocd_pkg.sv ====
// Behaviour
// - jump condition field is taken from bits 7:4 of the jump opcode byte
// - jump taken only when the flag test (codes 1, 2) or ext_cond_hit (codes 3..f) is true, else fall through
// - code 0000 never jumps; 0001 is S^V; 0010 is Z|(S^V)
// - opcode 04: first operand byte is source, second is destination of the sum
// - 8-bit register field selects 0..255; nibble E escapes to a working register
// - relative offset is signed 8-bit, added to the next instruction address
// - indexed location is base register plus sign-extended signed index
// - full register pair is an even address 00..fe; odd is invalid
// - extended register operand is a 12-bit address 000..fff
// - direct operand is a 16-bit program address 0000..ffff
// - bit index is three bits selecting bit 0..7 of the destination byte
// - polarity bit 0 clears the indexed bit, 1 sets it
// - immediate operand is an 8-bit value taken straight from the stream
package cocd_pkg;
    // =========================================================
    // register map
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_PC     = 8'h04;
    localparam logic [7:0]  ADDR_STAT   = 8'h08;
    localparam logic [7:0]  ADDR_JUMP   = 8'h0c;
    localparam logic [7:0]  ADDR_OPER   = 8'h10;
    localparam logic [7:0]  ADDR_ADD    = 8'h14;
    localparam int          CTRL_EN_BIT = 3;
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic        EN_RST      = 1'b1;
    localparam logic [15:0] PC_RST      = 16'h0000;
    // =========================================================
    // opcodes and codes
    localparam logic [7:0]  OPC_ADD      = 8'h04;
    localparam logic [3:0]  JR_LOW       = 4'hb;
    localparam logic [3:0]  JP_LOW       = 4'hd;
    localparam logic [3:0]  ESC_NIB      = 4'he;
    localparam logic [3:0]  NEVER_CODE   = 4'h0;
    localparam logic [3:0]  signed_below_code   = 4'h1;
    localparam logic [3:0]  signed_at_most_code = 4'h2;
    localparam int          FLAG_C = 3;
    localparam int          FLAG_Z = 2;
    localparam int          FLAG_S = 1;
    localparam int          FLAG_V = 0;
    // =========================================================
    // operand modes
    localparam logic [2:0]  MODE_REG       = 3'h0;
    localparam logic [2:0]  MODE_IMMEDIATE = 3'h1;
    localparam logic [2:0]  MODE_PAIR      = 3'h2;
    localparam logic [2:0]  MODE_WPAIR     = 3'h3;
    localparam logic [2:0]  MODE_EXT12     = 3'h4;
    localparam logic [2:0]  MODE_DIRECT16  = 3'h5;
    localparam logic [2:0]  MODE_BITOP     = 3'h6;
    localparam logic [2:0]  MODE_INDEXED   = 3'h7;
    localparam int          BIT_POL_POS    = 3;

    function automatic logic is_escaped(input logic [7:0] b);
        return b[7:4] == ESC_NIB;
    endfunction

    function automatic logic [15:0] sext8(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    function automatic logic two_bytes(input logic [2:0] m);
        return m[2];
    endfunction
endpackage

// ==== hw/cocd_if.sv ====
`timescale 1ns/1ns
interface cocd_if;
    logic [3:0]  jump_condition_field;
    logic [3:0]  flags;
    logic        ext_hit;
    logic        cond_true;
    logic [2:0]  mode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [15:0] value;
    logic        bad;
    logic        esc;
    modport core (output jump_condition_field, flags, ext_hit, mode, byte1, byte2,
                  input  cond_true, value, bad, esc);
    modport cond (input jump_condition_field, flags, ext_hit, output cond_true);
    modport oper (input mode, byte1, byte2, output value, bad, esc);
endinterface

// ==== hw/cocd_cond_eval.sv ====
`timescale 1ns/1ns
module cocd_cond_eval (
    cocd_if.cond c
);
    logic sv;
    always_comb begin
        sv = c.flags[cocd_pkg::FLAG_S] ^ c.flags[cocd_pkg::FLAG_V];
        if (c.jump_condition_field == cocd_pkg::NEVER_CODE) begin
            c.cond_true = 1'b0;
        end else if (c.jump_condition_field == cocd_pkg::signed_below_code) begin
            c.cond_true = sv;
        end else if (c.jump_condition_field == cocd_pkg::signed_at_most_code) begin
            c.cond_true = c.flags[cocd_pkg::FLAG_Z] | sv;
        end else begin
            c.cond_true = c.ext_hit;
        end
    end
endmodule

// ==== hw/cocd_oper_decode.sv ====
`timescale 1ns/1ns
module cocd_oper_decode (
    cocd_if.oper o
);
    logic [3:0] p;
    logic [2:0] idx;
    logic [7:0] bm;
    always_comb begin
        p     = o.byte1[3:0];
        idx   = o.byte1[2:0];
        bm    = 8'h01 << idx;
        o.bad = 1'b0;
        o.esc = 1'b0;
        case (o.mode)
            cocd_pkg::MODE_REG: begin
                o.esc   = cocd_pkg::is_escaped(o.byte1);
                o.value = o.esc ? {12'h000, p} : {8'h00, o.byte1};
            end
            cocd_pkg::MODE_IMMEDIATE: begin
                o.value = {8'h00, o.byte1};
            end
            cocd_pkg::MODE_PAIR: begin
                o.value = {8'h00, o.byte1};
                o.bad   = o.byte1[0];
            end
            cocd_pkg::MODE_WPAIR: begin
                o.value = {8'h00, p, p | 4'h1};
                o.bad   = p[0];
            end
            cocd_pkg::MODE_EXT12: begin
                o.value = {4'h0, o.byte1[3:0], o.byte2};
            end
            cocd_pkg::MODE_DIRECT16: begin
                o.value = {o.byte1, o.byte2};
            end
            cocd_pkg::MODE_BITOP: begin
                o.value = {8'h00, o.byte1[cocd_pkg::BIT_POL_POS] ? (o.byte2 | bm)
                                                                 : (o.byte2 & ~bm)};
            end
            default: begin
                o.value = {8'h00, o.byte1} + cocd_pkg::sext8(o.byte2);
            end
        endcase
    end
endmodule

// ==== hw/cocd_top.sv ====
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module cocd_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    input  wire logic        fetch_valid,
    input  wire logic [7:0]  fetch_byte,
    output wire logic        fetch_ready,
    input  wire logic [3:0]  cond_flags,
    input  wire logic        ext_cond_hit,
    output wire logic        jump_hit,
    output wire logic        jump_taken,
    output wire logic [15:0] jump_target,
    output wire logic        add_valid,
    output wire logic [7:0]  add_src,
    output wire logic [7:0]  add_dst,
    output wire logic        oper_valid,
    output wire logic [15:0] oper_value,
    output wire logic        oper_bad
);
    // =========================================================
    // state
    typedef enum logic [1:0] {ST_OP, ST_B1, ST_B2} cocd_st_e;

    typedef struct packed {
        cocd_st_e    st;
        logic [7:0]  opc;
        logic [7:0]  b1;
        logic [15:0] pc;
        logic [2:0]  mode;
        logic        en;
        logic        ack;
        logic [31:0] rdata;
        logic        jump_hit;
        logic        jump_taken;
        logic [3:0]  jump_code;
        logic [15:0] jump_target;
        logic        add_pulse;
        logic [7:0]  add_src;
        logic [7:0]  add_dst;
        logic        add_src_esc;
        logic        add_dst_esc;
        logic        oper_pulse;
        logic [2:0]  oper_mode;
        logic [15:0] oper_value;
        logic        oper_bad;
        logic        oper_esc;
    } cocd_state_s;

    cocd_state_s r;
    cocd_state_s next_r;

    cocd_if dif ();

    logic        bus_req;
    logic        accept;
    logic        is_jr;
    logic        is_jp;
    logic        is_add;
    logic [15:0] pc_next;
    logic [15:0] rel_target;
    logic [31:0] rd_mux;

    // =========================================================
    // decoders
    cocd_cond_eval u_cond (
        .c (dif.cond)
    );

    cocd_oper_decode u_oper (
        .o (dif.oper)
    );

    assign dif.jump_condition_field = r.opc[7:4];
    assign dif.flags   = cond_flags;
    assign dif.ext_hit = ext_cond_hit;
    assign dif.mode    = r.oper_mode;
    assign dif.byte1   = (r.st == ST_B1) ? fetch_byte : r.b1;
    assign dif.byte2   = fetch_byte;

    assign bus_req     = wb_cyc_i & wb_stb_i;
    assign fetch_ready = r.en;
    assign accept      = fetch_valid & r.en;
    assign is_add      = r.opc == cocd_pkg::OPC_ADD;
    assign is_jr       = r.opc[3:0] == cocd_pkg::JR_LOW;
    assign is_jp       = r.opc[3:0] == cocd_pkg::JP_LOW;
    assign pc_next     = r.pc + 16'h0001;
    assign rel_target  = pc_next + cocd_pkg::sext8(fetch_byte);

    // =========================================================
    // register read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (wb_adr_i == cocd_pkg::ADDR_CTRL) begin
            rd_mux = {28'h0000000, r.en, r.mode};
        end else if (wb_adr_i == cocd_pkg::ADDR_PC) begin
            rd_mux = {16'h0000, r.pc};
        end else if (wb_adr_i == cocd_pkg::ADDR_STAT) begin
            rd_mux = {22'h000000, r.st, r.opc};
        end else if (wb_adr_i == cocd_pkg::ADDR_JUMP) begin
            rd_mux = {11'h000, r.jump_code, r.jump_taken, r.jump_target};
        end else if (wb_adr_i == cocd_pkg::ADDR_OPER) begin
            rd_mux = {11'h000, r.oper_mode, r.oper_esc, r.oper_bad, r.oper_value};
        end else if (wb_adr_i == cocd_pkg::ADDR_ADD) begin
            rd_mux = {14'h0000, r.add_dst_esc, r.add_src_esc, r.add_dst, r.add_src};
        end
    end

    // =========================================================
    // next state
    always_comb begin
        next_r            = r;
        next_r.ack        = 1'b0;
        next_r.jump_hit   = 1'b0;
        next_r.add_pulse  = 1'b0;
        next_r.oper_pulse = 1'b0;

        if (accept) begin
            next_r.pc = pc_next;
            case (r.st)
                ST_OP: begin
                    next_r.opc       = fetch_byte;
                    next_r.oper_mode = r.mode;
                    next_r.st        = ST_B1;
                end
                ST_B1: begin
                    next_r.b1 = fetch_byte;
                    if (is_jr) begin
                        next_r.jump_hit    = 1'b1;
                        next_r.jump_code   = r.opc[7:4];
                        next_r.jump_taken  = dif.cond_true;
                        next_r.jump_target = dif.cond_true ? rel_target : pc_next;
                        next_r.pc          = dif.cond_true ? rel_target : pc_next;
                        next_r.st          = ST_OP;
                    end else if (is_jp || is_add || cocd_pkg::two_bytes(r.oper_mode)) begin
                        next_r.st = ST_B2;
                    end else begin
                        next_r.oper_pulse = 1'b1;
                        next_r.oper_value = dif.value;
                        next_r.oper_bad   = dif.bad;
                        next_r.oper_esc   = dif.esc;
                        next_r.st         = ST_OP;
                    end
                end
                ST_B2: begin
                    next_r.st = ST_OP;
                    if (is_add) begin
                        next_r.add_pulse   = 1'b1;
                        next_r.add_src     = r.b1;
                        next_r.add_dst     = fetch_byte;
                        next_r.add_src_esc = cocd_pkg::is_escaped(r.b1);
                        next_r.add_dst_esc = cocd_pkg::is_escaped(fetch_byte);
                    end else if (is_jp) begin
                        next_r.jump_hit    = 1'b1;
                        next_r.jump_code   = r.opc[7:4];
                        next_r.jump_taken  = dif.cond_true;
                        next_r.jump_target = dif.cond_true ? {r.b1, fetch_byte}
                                                           : pc_next;
                        next_r.pc          = dif.cond_true ? {r.b1, fetch_byte} : pc_next;
                    end else begin
                        next_r.oper_pulse = 1'b1;
                        next_r.oper_value = dif.value;
                        next_r.oper_bad   = dif.bad;
                        next_r.oper_esc   = dif.esc;
                    end
                end
                default: begin
                    next_r.st = ST_OP;
                end
            endcase
        end

        // bus access: the pc bytes that a write selects in wb_sel_i win over the fetch advance
        if (bus_req && !r.ack) begin
            next_r.ack   = 1'b1;
            next_r.rdata = rd_mux;
            if (wb_we_i) begin
                if (wb_adr_i == cocd_pkg::ADDR_CTRL && wb_sel_i[0]) begin
                    next_r.mode = wb_dat_i[2:0];
                    next_r.en   = wb_dat_i[cocd_pkg::CTRL_EN_BIT];
                end else if (wb_adr_i == cocd_pkg::ADDR_PC) begin
                    if (wb_sel_i[0]) begin
                        next_r.pc[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        next_r.pc[15:8] = wb_dat_i[15:8];
                    end
                    if (wb_sel_i[1:0] != 2'h0) begin
                        next_r.st = ST_OP;
                    end
                end
            end
        end

        if (!bus_req) begin
            next_r.ack = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r      <= '0;
            r.st   <= ST_OP;
            r.pc   <= cocd_pkg::PC_RST;
            r.mode <= cocd_pkg::MODE_RST;
            r.en   <= cocd_pkg::EN_RST;
        end else begin
            r <= next_r;
        end
    end

    // =========================================================
    // outputs
    assign wb_ack_o    = r.ack;
    assign wb_dat_o    = r.rdata;
    assign jump_hit    = r.jump_hit;
    assign jump_taken  = r.jump_taken;
    assign jump_target = r.jump_target;
    assign add_valid   = r.add_pulse;
    assign add_src     = r.add_src;
    assign add_dst     = r.add_dst;
    assign oper_valid  = r.oper_pulse;
    assign oper_value  = r.oper_value;
    assign oper_bad    = r.oper_bad;

    // =========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_never_code: assert property (
        jump_hit && r.jump_code == 4'h0 |-> !jump_taken)
        else $error("code zero took the jump");

    a_below_code: assert property (
        jump_hit && r.jump_code == 4'h1 |->
        jump_taken == ($past(cond_flags[1]) ^ $past(cond_flags[0])))
        else $error("signed below test wrong");

    a_at_most_code: assert property (
        jump_hit && r.jump_code == 4'h2 |->
        jump_taken == ($past(cond_flags[2]) | ($past(cond_flags[1]) ^ $past(cond_flags[0]))))
        else $error("signed at most test wrong");

    a_rel_target: assert property (
        accept && r.st == ST_B1 && is_jr && dif.cond_true && !bus_req |=>
        jump_hit && jump_target == $past(r.pc) + 16'h0001 + {{8{$past(fetch_byte[7])}},
                                                             $past(fetch_byte)})
        else $error("relative target wrong");

    a_fall_through: assert property (
        jump_hit && !jump_taken |-> jump_target == r.pc)
        else $error("untaken jump not at next address");

    a_add_fields: assert property (
        accept && r.st == ST_B2 && is_add |=>
        add_valid && add_src == $past(r.b1) && add_dst == $past(fetch_byte))
        else $error("add operand order wrong");

    a_pair_odd: assert property (
        oper_valid && r.oper_mode == 3'h2 |-> oper_bad == oper_value[0])
        else $error("odd pair not flagged");

    a_wpair_form: assert property (
        oper_valid && r.oper_mode == 3'h3 && !oper_bad |->
        oper_value[3:0] == oper_value[7:4] + 4'h1)
        else $error("working pair malformed");

    a_ext_range: assert property (
        oper_valid && r.oper_mode == 3'h4 |-> oper_value[15:12] == 4'h0)
        else $error("extended address above 12 bits");

    a_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // =========================================================
    // jump, add escape, operand result and fetch-disable checks

    a_code_field: assert property (
        jump_hit |-> r.jump_code == r.opc[7:4])
        else $error("condition field not from opcode high nibble");

    a_taken_pc: assert property (
        jump_hit && jump_taken && !$past(bus_req) |-> r.pc == jump_target)
        else $error("taken jump did not move the program counter");

    a_abs_target: assert property (
        accept && r.st == ST_B2 && is_jp && !is_add && dif.cond_true |=>
        jump_hit && jump_target == {$past(r.b1), $past(fetch_byte)})
        else $error("absolute target wrong");

    a_add_escape: assert property (
        add_valid |-> r.add_src_esc == (add_src[7:4] == 4'he) &&
        r.add_dst_esc == (add_dst[7:4] == 4'he))
        else $error("add escape marks wrong");

    a_reg_escape: assert property (
        oper_valid && r.oper_mode == 3'h0 |->
        (r.oper_esc ? oper_value[15:4] == 12'h000
                    : oper_value[15:8] == 8'h00 && oper_value[7:4] != 4'he))
        else $error("register escape decoded wrong");

    a_imm_value: assert property (
        accept && r.st == ST_B1 && r.oper_mode == 3'h1 && !is_jr && !is_jp && !is_add |=>
        oper_valid && oper_value == {8'h00, $past(fetch_byte)})
        else $error("immediate operand not passed through");

    a_index_sum: assert property (
        accept && r.st == ST_B2 && r.oper_mode == 3'h7 && !is_jp && !is_add |=>
        oper_valid && oper_value == {8'h00, $past(r.b1)} + {{8{$past(fetch_byte[7])}},
                                                             $past(fetch_byte)})
        else $error("indexed location wrong");

    a_direct_value: assert property (
        accept && r.st == ST_B2 && r.oper_mode == 3'h5 && !is_jp && !is_add |=>
        oper_valid && oper_value == {$past(r.b1), $past(fetch_byte)})
        else $error("direct address wrong");

    a_bit_polarity: assert property (
        accept && r.st == ST_B2 && r.oper_mode == 3'h6 && !is_jp && !is_add |=>
        ((oper_value[7:0] >> $past(r.b1[2:0])) & 8'h01) == {7'h00, $past(r.b1[3])})
        else $error("indexed bit not set to polarity");

    a_bit_others: assert property (
        accept && r.st == ST_B2 && r.oper_mode == 3'h6 && !is_jp && !is_add |=>
        ((oper_value[7:0] ^ $past(fetch_byte)) & ~(8'h01 << $past(r.b1[2:0]))) == 8'h00)
        else $error("bit operation touched other bits");

    a_wpair_bad: assert property (
        oper_valid && r.oper_mode == 3'h3 |-> oper_bad == oper_value[4])
        else $error("odd working pair not flagged");

    a_refused_byte: assert property (
        !r.en && !bus_req |=> r.pc == $past(r.pc) && r.st == $past(r.st))
        else $error("byte taken while fetch disabled");
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
    logic        clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, fetch_valid, ext_cond_hit;
    logic [7:0]  wb_adr_i, fetch_byte;
    logic [3:0]  wb_sel_i, cond_flags;
    logic [31:0] wb_dat_i, q;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, fetch_ready, jump_hit, jump_taken, add_valid, oper_valid, oper_bad;
    wire  [15:0] jump_target, oper_value;
    wire  [7:0]  add_src, add_dst;
    logic [15:0] r, pc;
    int          num_errors, comparisons;

    cocd_top dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .cond_flags(cond_flags),
        .ext_cond_hit(ext_cond_hit), .jump_hit(jump_hit), .jump_taken(jump_taken),
        .jump_target(jump_target), .add_valid(add_valid), .add_src(add_src),
        .add_dst(add_dst), .oper_valid(oper_valid), .oper_value(oper_value),
        .oper_bad(oper_bad));

    always #5 clk = ~clk;

    // =========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction

    function automatic logic cond(input logic [3:0] code, input logic [4:0] f);
        case (code)
            4'h0: return 1'b0;
            4'h1: return f[1] ^ f[0];
            4'h2: return f[2] | (f[1] ^ f[0]);
            default: return f[4];
        endcase
    endfunction

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic send(input logic [7:0] b);
        fetch_valid <= 1'b1;
        fetch_byte  <= b;
        @(posedge clk);
    endtask

    // kind 0 jump, 1 add, 2 operand
    task automatic finish_instr(input int kind);
        int   n;
        logic hit;
        fetch_valid <= 1'b0;
        n = 0;
        hit = 1'b0;
        while (!hit && n < 6) begin
            @(posedge clk);
            n++;
            hit = kind == 0 ? jump_hit === 1'b1 : kind == 1 ? add_valid === 1'b1
                : oper_valid === 1'b1;
        end
        chk(hit, 1'b1);
    endtask

    // =========================================================
    // scenarios
    task automatic do_jump(input logic [3:0] code, input logic abs_j, input logic fix,
                           input logic [7:0] off, input logic [4:0] fl);
        logic [7:0]  b1, b2;
        logic [4:0]  f;
        logic [15:0] nxt, tgt;
        logic        tk;
        r = lfsr(r);
        b1 = fix ? off : r[7:0];
        b2 = r[15:8];
        r = lfsr(r);
        f = fix ? fl : r[4:0];
        cond_flags   <= f[3:0];
        ext_cond_hit <= f[4];
        tk = cond(code, f);
        send({code, abs_j ? 4'hd : 4'hb});
        send(b1);
        if (abs_j) send(b2);
        nxt = pc + (abs_j ? 16'h0003 : 16'h0002);
        tgt = abs_j ? {b1, b2} : nxt + {{8{b1[7]}}, b1};
        finish_instr(0);
        chk(jump_taken, tk);
        chk(jump_target, tk ? tgt : nxt);
        pc = tk ? tgt : nxt;
        wb(1'b0, 8'h0c, 32'h0);
        chk(q[20:17], code);
    endtask

    task automatic do_oper(input logic [2:0] m, input logic [7:0] b1, input logic [7:0] b2);
        logic [15:0] ev;
        logic [7:0]  d;
        logic [3:0]  p;
        wb(1'b1, 8'h00, {28'h0, 1'b1, m});
        r = lfsr(r);
        send({r[7:4], 4'h1});
        send(b1);
        if (m[2]) send(b2);
        finish_instr(2);
        p = b1[3:0];
        d = b2;
        d[b1[2:0]] = b1[3];
        case (m)
            3'h0: ev = b1[7:4] == 4'he ? {12'h0, p} : {8'h0, b1};
            3'h3: ev = {8'h0, p, p | 4'h1};
            3'h4: ev = {4'h0, p, b2};
            3'h5: ev = {b1, b2};
            3'h6: ev = {8'h0, d};
            3'h7: ev = {8'h0, b1} + {{8{b2[7]}}, b2};
            default: ev = {8'h0, b1};
        endcase
        chk(oper_value, ev);
        chk(oper_bad, (m == 3'h2 || m == 3'h3) & b1[0]);
    endtask

    // =========================================================
    // main sequence
    initial begin
        clk = 0; srst = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0;
        wb_sel_i = 4'hf; wb_dat_i = 0; fetch_valid = 0; fetch_byte = 0;
        cond_flags = 0; ext_cond_hit = 0; num_errors = 0; comparisons = 0;
        r = 16'd60303;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        chk(fetch_ready, 1'b1);
        wb(1'b1, 8'h04, 32'h0100);
        pc = 16'h0100;
        do_jump(4'h1, 1'b0, 1'b1, 8'h7f, 5'b00010);
        do_jump(4'h2, 1'b0, 1'b1, 8'h80, 5'b00100);
        do_jump(4'h0, 1'b0, 1'b1, 8'h10, 5'b01111);
        do_jump(4'h1, 1'b0, 1'b1, 8'h05, 5'b00011);
        do_jump(4'h2, 1'b1, 1'b1, 8'hff, 5'b00000);
        for (int i = 0; i < 64; i++) do_jump(i[3:0], i[4], 1'b0, 8'h00, 5'h00);
        wb(1'b1, 8'h00, 32'h0);
        chk(fetch_ready, 1'b0);
        send(8'h04);
        send(8'h21);
        fetch_valid <= 1'b0;
        wb(1'b1, 8'h00, 32'h8);
        wb(1'b0, 8'h04, 32'h0);
        chk(q[15:0], pc);
        wb_sel_i <= 4'h2;
        wb(1'b1, 8'h04, 32'h5aa5);
        wb_sel_i <= 4'hf;
        wb(1'b0, 8'h04, 32'h0);
        chk(q[15:0], {8'h5a, pc[7:0]});
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            send(8'h04);
            send({r[7:4] == 4'he ? 4'h1 : r[7:4], r[3:0]});
            send(r[15:8]);
            finish_instr(1);
            chk(add_src, {r[7:4] == 4'he ? 4'h1 : r[7:4], r[3:0]});
            chk(add_dst, r[15:8]);
        end
        send(8'h04);
        send(8'he8);
        send(8'h43);
        finish_instr(1);
        wb(1'b0, 8'h14, 32'h0);
        chk(q[17:8], 10'h143);
        do_oper(3'h0, 8'he5, 8'h00);
        wb(1'b0, 8'h10, 32'h0);
        chk(q[20:0], {3'h0, 2'b10, 16'h0005});
        do_oper(3'h7, 8'h10, 8'h80);
        do_oper(3'h6, 8'h0f, 8'h00);
        do_oper(3'h6, 8'h00, 8'hff);
        for (int i = 0; i < 48; i++) begin
            r = lfsr(r);
            do_oper(i[2:0], r[7:0], r[15:8]);
        end
        wb(1'b1, 8'h3c, 32'hffff_ffff);
        wb(1'b0, 8'h3c, 32'h0);
        chk(q, 32'h0);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t run did not finish", $time);
        end_of_test();
    end
endmodule
